// ---- core/xcm_device.sv ----
// device end: receive framing on client bus and managed-slave port
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - eight lanes, later lanes 4-7
// - lane n on bits 8n+7:8n
// - control bit marks idle/start/term/error
// - client starts frames in lane 0 or 4
// - client terminates, idles fill later lanes
// - transmit error characters carried toward link
// - receive start only in lane 0/4
// - receive terminate may sit in any lane
// - receive errors inside a frame shown as error characters, except in the start word
// - device only answers, never initiates
// - management as four one-way signals
// - map select captured only after reset
// - select picks PCS/PMA, DTE or PHY map
// - ignore frames for other port addresses
// - op 00 loads current address
// - op 01 writes addressed register
// - op 11 reads addressed register
// - op 10 reads then increments address
// - build option swaps port for config vector
// - one core clock for everything
// - async reset synchronised internally
module xcm_device
   import xcm_pkg::*;
#(
   parameter bit MDIO_EN = 1'b1,
   parameter int DEPTH   = REG_DEPTH
)
(
   input  wire logic              i_clock,
   input  wire logic              i_reset_n,
   xcm_if.device                  bus,
   input  wire logic [1:0]        i_map_sel,
   input  wire logic [4:0]        i_port_addr,
   input  wire logic [15:0]       i_config_vec,
   output logic [DATA_W-1:0]      o_link_tx_data,
   output logic [LANES-1:0]       o_link_tx_ctrl,
   input  wire logic [DATA_W-1:0] i_link_rx_data,
   input  wire logic [LANES-1:0]  i_link_rx_ctrl,
   input  wire logic [LANES-1:0]  i_link_rx_err,
   output logic [15:0]            o_reg0
);
   // two-stage reset synchroniser, release on the core clock
   logic [SYNC_STAGES-1:0] rst_sync;
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         rst_sync <= '0;
      else
         rst_sync <= {rst_sync[SYNC_STAGES-2:0], 1'b1};
   end
   wire rst_n = rst_sync[SYNC_STAGES-1];
   // transmit words pass to the link unchanged, error lanes included
   logic [DATA_W-1:0] ltxd, next_ltxd, rxd, next_rxd;
   logic [LANES-1:0]  ltxc, next_ltxc, rxc, next_rxc;
   logic              in_frame, next_in_frame;
   always_comb
   begin
      next_ltxd     = bus.txd;
      next_ltxc     = bus.txc;
      next_in_frame = in_frame;
      next_rxd      = i_link_rx_data;
      next_rxc      = i_link_rx_ctrl;
      for (int n = 0; n < LANES; n++)
      begin
         // flagged lanes become error characters in the words after a start, up to and including the terminate word
         if (i_link_rx_err[n] && in_frame)
         begin
            next_rxd[8*n +: 8] = CH_ERROR;
            next_rxc[n]        = 1'b1;
         end
         // a start outside lanes 0 and 4 is not legal here
         if (i_link_rx_ctrl[n] && i_link_rx_data[8*n +: 8] == CH_START && n != 0 && n != 4)
         begin
            next_rxd[8*n +: 8] = CH_ERROR;
         end
      end
      for (int n = 0; n < LANES; n++)
      begin
         if (i_link_rx_ctrl[n] && i_link_rx_data[8*n +: 8] == CH_START && (n == 0 || n == 4))
            next_in_frame = 1'b1;
         if (i_link_rx_ctrl[n] && i_link_rx_data[8*n +: 8] == CH_TERM)
            next_in_frame = 1'b0;
      end
   end
   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ltxd <= {LANES{CH_IDLE}}; ltxc <= '1; rxd <= {LANES{CH_IDLE}}; rxc <= '1;
         in_frame <= 1'b0;
      end
      else
      begin
         ltxd <= next_ltxd; ltxc <= next_ltxc; rxd <= next_rxd; rxc <= next_rxc;
         in_frame <= next_in_frame;
      end
   end
   // management slave; mdc is sampled as an ordinary input
   logic [1:0]  map, next_map;
   logic        cap, next_cap;
   xcm_state_t  st, next_st;
   logic [5:0]  cnt, next_cnt;
   logic [13:0] hdr, next_hdr;
   logic [15:0] dat, next_dat;
   logic [15:0] cur, next_cur;
   logic [15:0] regs [DEPTH];
   logic [15:0] shout, next_shout;
   logic        mdc_q, dout, next_dout, doe, next_doe, we;
   logic [4:0]  ones, next_ones;
   wire rise = bus.mdc & ~mdc_q;
   wire fall = ~bus.mdc & mdc_q;
   wire [1:0] op = hdr[11:10];
   wire dev_ok = (map[1] == 1'b0) ? (hdr[4:0] == DEV_PMA || hdr[4:0] == DEV_PCS) :
                 (map == MAP_DTE) ? (hdr[4:0] == DEV_DTEX) : (hdr[4:0] == DEV_PHYX);
   wire hit = MDIO_EN && hdr[13:12] == MD_ST && hdr[9:5] == i_port_addr && dev_ok;
   wire [15:0] rdval = (cur < 16'(DEPTH)) ? regs[cur[$clog2(DEPTH)-1:0]] : REG_RESET;
   always_comb
   begin
      next_map   = map;
      next_cap   = 1'b1;
      next_st    = st;
      next_cnt   = cnt;
      next_hdr   = hdr;
      next_dat   = dat;
      next_cur   = cur;
      next_shout = shout;
      next_dout  = dout;
      next_doe   = doe;
      next_ones  = ones;
      we         = 1'b0;
      if (!cap)
         next_map = i_map_sel;
      unique case (st)
         XCM_IDLE:
         begin
            if (rise)
            begin
               next_ones = bus.mdio_line ? ((ones == 5'h1f) ? ones : ones + 5'h1) : 5'h0;
               if (!bus.mdio_line && ones == 5'h1f)
               begin
                  next_st  = XCM_HDR;
                  next_hdr = 14'h0;
                  next_cnt = 6'h1;
               end
            end
         end
         XCM_HDR:
         begin
            if (rise)
            begin
               next_hdr = {hdr[12:0], bus.mdio_line};
               next_cnt = cnt + 6'h1;
               if (cnt == 6'(HDR_BITS - 1))
               begin
                  next_st  = XCM_TA;
                  next_cnt = CNT_ZERO;
               end
            end
         end
         XCM_TA:
         begin
            // drive only on reads that hit this port and device
            if (fall && hit && op[1])
            begin
               next_doe   = 1'b1;
               next_dout  = (cnt == 6'h0) ? 1'b1 : 1'b0;
               next_shout = rdval;
            end
            if (rise)
            begin
               next_cnt = cnt + 6'h1;
               if (cnt == 6'(TA_BITS - 1))
               begin
                  next_st  = hit ? XCM_DATA : XCM_SKIP;
                  next_cnt = CNT_ZERO;
               end
            end
         end
         XCM_DATA, XCM_SKIP:
         begin
            if (fall && doe && st == XCM_DATA)
            begin
               next_dout  = shout[15];
               next_shout = {shout[14:0], 1'b0};
            end
            if (rise)
            begin
               next_dat = {dat[14:0], bus.mdio_line};
               next_cnt = cnt + 6'h1;
               if (cnt == 6'(DAT_BITS - 1))
               begin
                  next_st   = XCM_IDLE;
                  next_ones = 5'h0;
                  next_doe  = 1'b0;
                  if (st == XCM_DATA)
                  begin
                     unique case (op)
                        OP_ADDR:  next_cur = {dat[14:0], bus.mdio_line};
                        OP_WRITE: we = 1'b1;
                        OP_RDINC: next_cur = cur + 16'h1;
                        OP_READ:  next_cur = cur;
                     endcase
                  end
               end
            end
         end
         default: next_st = XCM_IDLE;
      endcase
   end
   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         map <= MAP_PCS0; cap <= 1'b0; st <= XCM_IDLE; cnt <= CNT_ZERO; hdr <= '0;
         dat <= '0; cur <= '0; shout <= '0; dout <= 1'b1; doe <= 1'b0; ones <= '0;
         mdc_q <= 1'b0;
      end
      else
      begin
         map <= next_map; cap <= next_cap; st <= next_st; cnt <= next_cnt;
         hdr <= next_hdr; dat <= next_dat; cur <= next_cur; shout <= next_shout;
         dout <= next_dout; doe <= next_doe; ones <= next_ones; mdc_q <= bus.mdc;
      end
   end
   // register file; a write lands on the last data rise
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++)
      begin : g_reg
         always_ff @(posedge i_clock or negedge rst_n)
         begin
            if (!rst_n)
               regs[g] <= REG_RESET;
            else if (!MDIO_EN && g == 0)
               regs[g] <= i_config_vec;
            else if (we && cur == 16'(g))
               regs[g] <= {dat[14:0], bus.mdio_line};
         end
      end
   endgenerate
   assign o_link_tx_data = ltxd;
   assign o_link_tx_ctrl = ltxc;
   assign bus.rxd        = rxd;
   assign bus.rxc        = rxc;
   assign bus.mdio_d_o   = dout;
   assign bus.mdio_d_oe  = doe;
   assign o_reg0         = regs[0];
endmodule
`default_nettype wire

// ---- core/xcm_pkg.sv ----
// shared constants for the client bus and management port
package xcm_pkg;
   localparam int          LANES        = 8;
   localparam int          DATA_W       = 64;
   localparam logic [7:0]  CH_IDLE      = 8'h07;
   localparam logic [7:0]  CH_START     = 8'hfb;
   localparam logic [7:0]  CH_TERM      = 8'hfd;
   localparam logic [7:0]  CH_ERROR     = 8'hfe;
   localparam logic [1:0]  MD_ST        = 2'h0;
   localparam logic [1:0]  OP_ADDR      = 2'h0;
   localparam logic [1:0]  OP_WRITE     = 2'h1;
   localparam logic [1:0]  OP_RDINC     = 2'h2;
   localparam logic [1:0]  OP_READ      = 2'h3;
   localparam logic [1:0]  MAP_PCS0     = 2'h0;
   localparam logic [1:0]  MAP_PCS1     = 2'h1;
   localparam logic [1:0]  MAP_DTE      = 2'h2;
   localparam logic [1:0]  MAP_PHY      = 2'h3;
   localparam logic [4:0]  DEV_PMA      = 5'h01;
   localparam logic [4:0]  DEV_PCS      = 5'h03;
   localparam logic [4:0]  DEV_PHYX     = 5'h04;
   localparam logic [4:0]  DEV_DTEX     = 5'h05;
   localparam int          PRE_BITS     = 32;
   localparam int          HDR_BITS     = 14;
   localparam int          TA_BITS      = 2;
   localparam int          DAT_BITS     = 16;
   localparam int          MDC_DIV      = 8;
   localparam int          SYNC_STAGES  = 2;
   localparam int          REG_DEPTH    = 16;
   localparam logic [15:0] REG_RESET    = 16'h0000;
   localparam logic [5:0]  CNT_ZERO     = 6'h00;
   typedef enum logic [2:0]
   {
      XCM_IDLE = 3'b000,
      XCM_HDR  = 3'b001,
      XCM_TA   = 3'b010,
      XCM_DATA = 3'b011,
      XCM_SKIP = 3'b100
   } xcm_state_t;
endpackage

// ---- core/xcm_if.sv ----
// client bus and management wires between station/client and device
`timescale 1ns/1ps
`default_nettype none
interface xcm_if;
   import xcm_pkg::*;
   logic [DATA_W-1:0] txd;
   logic [LANES-1:0]  txc;
   logic [DATA_W-1:0] rxd;
   logic [LANES-1:0]  rxc;
   logic              mdc;
   logic              mdio_m_o;
   logic              mdio_m_oe;
   logic              mdio_d_o;
   logic              mdio_d_oe;
   wire               mdio_line = (mdio_m_oe ? mdio_m_o : 1'b1) & (mdio_d_oe ? mdio_d_o : 1'b1);
   modport device (input txd, txc, mdc, mdio_line, output rxd, rxc, mdio_d_o, mdio_d_oe);
   modport client (input rxd, rxc, mdio_line, output txd, txc, mdc, mdio_m_o, mdio_m_oe);
endinterface
`default_nettype wire

// ---- core/xcm_client.sv ----
// client end: registered transmit path and management station master
`timescale 1ns/1ps
`default_nettype none
module xcm_client
   import xcm_pkg::*;
(
   input  wire logic              i_clock,
   input  wire logic              i_reset_n,
   xcm_if.client                  bus,
   input  wire logic [DATA_W-1:0] i_tx_data,
   input  wire logic [LANES-1:0]  i_tx_ctrl,
   output logic [DATA_W-1:0]      o_rx_data,
   output logic [LANES-1:0]       o_rx_ctrl,
   input  wire logic              i_md_req,
   input  wire logic [1:0]        i_md_op,
   input  wire logic [4:0]        i_md_prtad,
   input  wire logic [4:0]        i_md_devad,
   input  wire logic [15:0]       i_md_wdata,
   output logic                   o_md_busy,
   output logic                   o_md_done,
   output logic [15:0]            o_md_rdata
);
   // user provides framed words; passed straight, registered
   logic [DATA_W-1:0] txd, next_txd;
   logic [LANES-1:0]  txc, next_txc;
   logic [DATA_W-1:0] rxd, next_rxd;
   logic [LANES-1:0]  rxc, next_rxc;
   logic [63:0] sh, next_sh;
   logic [6:0]  bitn, next_bitn;
   logic [2:0]  div, next_div;
   logic        mdc, next_mdc;
   logic        busy, next_busy;
   logic        done, next_done;
   logic        rd, next_rd;
   logic [15:0] rdat, next_rdat;
   logic        mo, next_mo;
   logic        moe, next_moe;
   localparam logic [6:0] FRAME_LEN = 7'(PRE_BITS + HDR_BITS + TA_BITS + DAT_BITS);
   always_comb
   begin
      next_txd  = i_tx_data;
      next_txc  = i_tx_ctrl;
      next_rxd  = bus.rxd;
      next_rxc  = bus.rxc;
      next_sh   = sh;
      next_bitn = bitn;
      next_div  = div + 3'h1;
      next_mdc  = mdc;
      next_busy = busy;
      next_done = 1'b0;
      next_rd   = rd;
      next_rdat = rdat;
      next_mo   = mo;
      next_moe  = moe;
      if (!busy)
      begin
         next_div  = 3'h0;
         next_mdc  = 1'b0;
         if (i_md_req)
         begin
            next_busy = 1'b1;
            next_rd   = i_md_op[1];
            next_sh   = {32'hffffffff, MD_ST, i_md_op, i_md_prtad, i_md_devad,
                         2'b10, i_md_wdata};
            next_bitn = 7'h00;
            next_mo   = 1'b1;
            next_moe  = 1'b1;
         end
      end
      else if (div == 3'(MDC_DIV / 2 - 1))
      begin
         next_div = 3'h0;
         next_mdc = ~mdc;
         if (mdc)
         begin
            // falling edge: present next bit
            next_sh   = {sh[62:0], 1'b1};
            next_bitn = bitn + 7'h1;
            next_mo   = sh[62];
            if (rd && bitn + 7'h1 >= 7'(PRE_BITS + HDR_BITS))
               next_moe = 1'b0;
            if (bitn + 7'h1 == FRAME_LEN)
            begin
               next_busy = 1'b0;
               next_done = 1'b1;
               next_moe  = 1'b0;
            end
         end
         else if (rd && bitn >= 7'(PRE_BITS + HDR_BITS + TA_BITS))
            next_rdat = {rdat[14:0], bus.mdio_line};
      end
   end
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         txd <= '0; txc <= '1; rxd <= '0; rxc <= '0;
         sh <= '0; bitn <= '0; div <= '0; mdc <= 1'b0; busy <= 1'b0; done <= 1'b0;
         rd <= 1'b0; rdat <= '0; mo <= 1'b1; moe <= 1'b0;
      end
      else
      begin
         txd <= next_txd; txc <= next_txc; rxd <= next_rxd; rxc <= next_rxc;
         sh <= next_sh; bitn <= next_bitn; div <= next_div; mdc <= next_mdc;
         busy <= next_busy; done <= next_done; rd <= next_rd; rdat <= next_rdat;
         mo <= next_mo; moe <= next_moe;
      end
   end
   assign bus.txd       = txd;
   assign bus.txc       = txc;
   assign bus.mdc       = mdc;
   assign bus.mdio_m_o  = mo;
   assign bus.mdio_m_oe = moe;
   assign o_rx_data     = rxd;
   assign o_rx_ctrl     = rxc;
   assign o_md_busy     = busy;
   assign o_md_done     = done;
   assign o_md_rdata    = rdat;
endmodule
`default_nettype wire

// ---- verif/xcm_assertions.sv ----
// concurrent checks on the client bus and management wires
`timescale 1ns/1ps
`default_nettype none
module xcm_assertions
   import xcm_pkg::*;
(
   input  wire logic              i_clock,
   input  wire logic              i_reset_n,
   input  wire logic [DATA_W-1:0] rxd,
   input  wire logic [LANES-1:0]  rxc,
   input  wire logic              mdc,
   input  wire logic              mdio_m_o,
   input  wire logic              mdio_m_oe,
   input  wire logic              mdio_d_o,
   input  wire logic              mdio_d_oe
);
   logic       bad_start;
   logic       bad_pad;
   logic       bad_code;
   logic [7:0] oe_cnt;
   logic [7:0] next_oe_cnt;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   always_comb
   begin
      bad_start = 1'b0;
      bad_pad   = 1'b0;
      bad_code  = 1'b0;
      for (int n = 0; n < LANES; n++)
      begin
         if (rxc[n] && rxd[8*n +: 8] == CH_START && n != 0 && n != 4)
            bad_start = 1'b1;
         if (rxc[n] && !(rxd[8*n +: 8] inside {CH_IDLE, CH_START, CH_TERM, CH_ERROR}))
            bad_code = 1'b1;
         for (int m = n + 1; m < LANES; m++)
            if (rxc[n] && rxd[8*n +: 8] == CH_TERM && !(rxc[m] && rxd[8*m +: 8] == CH_IDLE))
               bad_pad = 1'b1;
      end
      // counts cycles the device has been driving the data line
      next_oe_cnt = mdio_d_oe ? oe_cnt + 8'h01 : 8'h00;
   end
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         oe_cnt <= 8'h00;
      else
         oe_cnt <= next_oe_cnt;
   end
   sequence s_mdc_rise;
      $rose(mdc);
   endsequence
   sequence s_mdc_high;
      mdc [*4] ##1 !mdc;
   endsequence
   AST_RX_START_LANE: assert property (!bad_start)
      else $error("receive start outside lane 0 or 4");
   AST_RX_TERM_PAD: assert property (!bad_pad)
      else $error("receive lanes after terminate not idle");
   AST_RX_CTRL_CODE: assert property (!bad_code)
      else $error("receive control lane with unknown code");
   AST_NO_CONTENTION: assert property (mdio_d_oe |-> !mdio_m_oe)
      else $error("device and station drive data together");
   AST_MDC_HALF_PERIOD: assert property (s_mdc_rise |-> s_mdc_high)
      else $error("management clock high phase not four cycles");
   AST_STA_STABLE: assert property (mdio_m_oe && $rose(mdc) |-> $stable(mdio_m_o))
      else $error("station data changed at rising clock");
   AST_DEV_STABLE: assert property (mdio_d_oe && $rose(mdc) |-> $stable(mdio_d_o))
      else $error("device data changed at rising clock");
   AST_PREAMBLE_ONE: assert property ($rose(mdio_m_oe) |-> mdio_m_o)
      else $error("frame does not open with a preamble one");
   AST_DEV_OE_LEN: assert property (oe_cnt <= 8'h94)
      else $error("device drove longer than turnaround and data");
   AST_DEV_OE_PAUSE: assert property ($fell(mdio_d_oe) |-> !mdio_d_oe [*8])
      else $error("device drove again without a new frame");
endmodule
`default_nettype wire

// ---- verif/xgmii_client_mdio_mgmt_tb.sv ----
// self-checking bench joining the client and device ends
`timescale 1ns/1ps
`default_nettype none
module xgmii_client_mdio_mgmt_tb;
   import xcm_pkg::*;
   localparam logic [4:0]  PA   = 5'h0a;
   localparam logic [63:0] IDLE = 64'h0707070707070707;
   logic              clk     = 1'b0;
   logic              rst_n   = 1'b0;
   logic [63:0]       tx_data = IDLE;
   logic [7:0]        tx_ctrl = 8'hff;
   logic [63:0]       rx_in   = IDLE;
   logic [7:0]        rxc_in  = 8'hff;
   logic [7:0]        rx_err  = 8'h00;
   logic              md_req  = 1'b0;
   logic [1:0]        md_op   = 2'h0;
   logic [4:0]        md_prt  = 5'h00;
   logic [4:0]        md_dev  = 5'h00;
   logic [15:0]       md_wd   = 16'h0000;
   logic [1:0]        map_sel = 2'h0;
   logic [63:0]       rx_data;
   logic [7:0]        rx_ctrl;
   logic              md_busy;
   logic              md_done;
   logic [15:0]       md_rdata;
   logic [63:0]       link_data;
   logic [7:0]        link_ctrl;
   logic [15:0]       reg0;
   logic [15:0]       cfg_vec = 16'h0000;
   logic [15:0]       cfg_reg0;
   int                bad_count = 0;
   int                compares  = 0;
   always #5 clk = ~clk;
   xcm_if xcm_if_i ();
   xcm_client xcm_client_i (.i_clock(clk), .i_reset_n(rst_n), .bus(xcm_if_i),
      .i_tx_data(tx_data), .i_tx_ctrl(tx_ctrl), .o_rx_data(rx_data), .o_rx_ctrl(rx_ctrl),
      .i_md_req(md_req), .i_md_op(md_op), .i_md_prtad(md_prt), .i_md_devad(md_dev),
      .i_md_wdata(md_wd), .o_md_busy(md_busy), .o_md_done(md_done), .o_md_rdata(md_rdata));
   xcm_device #(.MDIO_EN(1'b1), .DEPTH(REG_DEPTH)) xcm_device_i (.i_clock(clk),
      .i_reset_n(rst_n), .bus(xcm_if_i), .i_map_sel(map_sel), .i_port_addr(PA),
      .i_config_vec(cfg_vec), .o_link_tx_data(link_data), .o_link_tx_ctrl(link_ctrl),
      .i_link_rx_data(rx_in), .i_link_rx_ctrl(rxc_in), .i_link_rx_err(rx_err), .o_reg0(reg0));
   // second device built without the management port; its bus is held quiet
   xcm_if xcm_if_c ();
   assign xcm_if_c.txd       = IDLE;
   assign xcm_if_c.txc       = 8'hff;
   assign xcm_if_c.mdc       = 1'b0;
   assign xcm_if_c.mdio_m_o  = 1'b1;
   assign xcm_if_c.mdio_m_oe = 1'b0;
   xcm_device #(.MDIO_EN(1'b0), .DEPTH(REG_DEPTH)) xcm_device_cfg_i (.i_clock(clk),
      .i_reset_n(rst_n), .bus(xcm_if_c), .i_map_sel(map_sel), .i_port_addr(PA),
      .i_config_vec(cfg_vec), .o_link_tx_data(), .o_link_tx_ctrl(),
      .i_link_rx_data(IDLE), .i_link_rx_ctrl(8'hff), .i_link_rx_err(8'h00),
      .o_reg0(cfg_reg0));
   xcm_assertions xcm_assertions_i (.i_clock(clk), .i_reset_n(rst_n), .rxd(xcm_if_i.rxd),
      .rxc(xcm_if_i.rxc), .mdc(xcm_if_i.mdc), .mdio_m_o(xcm_if_i.mdio_m_o),
      .mdio_m_oe(xcm_if_i.mdio_m_oe), .mdio_d_o(xcm_if_i.mdio_d_o),
      .mdio_d_oe(xcm_if_i.mdio_d_oe));
   task automatic results();
      if (bad_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic do_reset(input logic [1:0] map);
      @(posedge clk);
      rst_n   <= 1'b0;
      map_sel <= map;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   task automatic md(input logic [1:0] op, input logic [4:0] prt, input logic [4:0] dev,
                     input logic [15:0] wd);
      int n;
      @(posedge clk);
      md_req <= 1'b1;
      md_op  <= op;
      md_prt <= prt;
      md_dev <= dev;
      md_wd  <= wd;
      @(posedge clk);
      md_req <= 1'b0;
      #1;
      check("md_busy", 64'h1, 64'(md_busy));
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (md_done !== 1'b1 && n < 1000);
      if (n >= 1000)
      begin
         bad_count++;
         results();
      end
      check("md_busy", 64'h0, 64'(md_busy));
   endtask
   task automatic rd(input logic [1:0] op, input logic [4:0] prt, input logic [4:0] dev,
                     input logic [15:0] exp);
      md(op, prt, dev, 16'h0000);
      check("md_rdata", 64'(exp), 64'(md_rdata));
   endtask
   task automatic t_tx(input logic [63:0] d, input logic [7:0] c);
      @(posedge clk);
      tx_data <= d;
      tx_ctrl <= c;
      repeat (2) @(posedge clk);
      #1;
      check("link_data", d, link_data);
      check("link_ctrl", 64'(c), 64'(link_ctrl));
   endtask
   task automatic t_rx();
      logic [63:0] w [6] = '{64'hd5555555555555fb, 64'h0706050403020100, 64'h07070707fd0a0b0c,
                             64'h555555fb07070707, 64'h07070707070707fd, 64'h0707070707fb0707};
      logic [7:0]  c [6] = '{8'h01, 8'h00, 8'hf8, 8'h1f, 8'hff, 8'hff};
      int          n;
      fork
         begin
            for (int i = 0; i < 6; i++)
            begin
               @(posedge clk);
               rx_in  <= w[i];
               rxc_in <= c[i];
               rx_err <= (i == 1) ? 8'hf0 : 8'h00;
            end
            @(posedge clk);
            rx_in  <= IDLE;
            rxc_in <= 8'hff;
            rx_err <= 8'h00;
         end
         begin
            n = 0;
            do
            begin
               @(posedge clk);
               #1;
               n++;
            end
            while (rx_ctrl !== 8'h01 && n < 12);
            check("rx start seen", 64'h0, (n >= 12) ? 64'h1 : 64'h0);
            if (n >= 12)
               results();
            check("rx lane0 start", w[0], rx_data);
            @(posedge clk);
            #1;
            check("rx error lanes", 64'hfefefefe03020100, rx_data);
            check("rx error ctrl", 64'hf0, 64'(rx_ctrl));
            for (int i = 2; i < 6; i++)
            begin
               @(posedge clk);
               #1;
               // an illegal start lane comes back as an error character
               check("rx word", (i == 5) ? 64'h0707070707fe0707 : w[i], rx_data);
               check("rx ctrl", 64'(c[i]), 64'(rx_ctrl));
            end
         end
      join
   endtask
   task automatic t_md_ops();
      md(OP_ADDR, PA, DEV_PCS, 16'h0003);
      md(OP_WRITE, PA, DEV_PCS, 16'h1234);
      md(OP_ADDR, PA, DEV_PCS, 16'h0002);
      md(OP_WRITE, PA, DEV_PCS, 16'hbeef);
      rd(OP_READ, PA, DEV_PCS, 16'hbeef);
      rd(OP_RDINC, PA, DEV_PCS, 16'hbeef);
      rd(OP_RDINC, PA, DEV_PCS, 16'h1234);
      rd(OP_READ, PA, DEV_PCS, REG_RESET);
   endtask
   task automatic t_md_refuse();
      @(posedge clk);
      map_sel <= MAP_PHY;
      rd(OP_READ, PA ^ 5'h01, DEV_PCS, 16'hffff);
      md(OP_ADDR, PA ^ 5'h01, DEV_PCS, 16'h0002);
      rd(OP_READ, PA, DEV_PCS, REG_RESET);
      rd(OP_READ, PA, DEV_PHYX, 16'hffff);
      md(OP_ADDR, PA, DEV_PCS, 16'h0002);
      rd(OP_READ, PA, DEV_PMA, 16'hbeef);
   endtask
   task automatic t_md_map();
      logic [1:0] m;
      logic [4:0] own;
      for (int k = 0; k < 4; k++)
      begin
         m   = k[1:0];
         own = (m == MAP_DTE) ? DEV_DTEX : (m == MAP_PHY) ? DEV_PHYX : DEV_PCS;
         do_reset(m);
         rd(OP_READ, PA, own, REG_RESET);
         rd(OP_READ, PA, (m == MAP_DTE) ? DEV_PHYX : DEV_DTEX, 16'hffff);
      end
      check("reg0", 64'(REG_RESET), 64'(reg0));
      md(OP_ADDR, PA, own, 16'h0000);
      md(OP_WRITE, PA, own, 16'ha5a5);
      check("reg0", 64'h000000000000a5a5, 64'(reg0));
   endtask
   task automatic t_cfg();
      @(posedge clk);
      cfg_vec <= 16'h5a3c;
      repeat (2) @(posedge clk);
      #1;
      check("cfg reg0", 64'h0000000000005a3c, 64'(cfg_reg0));
      check("reg0", 64'h000000000000a5a5, 64'(reg0));
   endtask
   initial
   begin
      do_reset(MAP_PCS0);
      t_tx(64'hd5555555555555fb, 8'h01);
      t_tx(64'hfefe0403020100fe, 8'hc1);
      t_tx(64'h070707070707fd11, 8'hfe);
      t_tx(64'h333333fb07070707, 8'h1f);
      t_tx(IDLE, 8'hff);
      t_rx();
      t_md_ops();
      t_md_refuse();
      t_md_map();
      t_cfg();
      results();
   end
endmodule
`default_nettype wire
